/* File: pkg/spi_audio_pkg.sv */
// Shared constants and types for the serial audio error and framing control block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package spi_audio_pkg;

	// Register byte offsets on the Wishbone bus.
	localparam logic [7:0] OFF_CONTROL_TWO = 8'h00;
	localparam logic [7:0] OFF_INT_STATUS  = 8'h04;
	localparam logic [7:0] OFF_INT_MASK    = 8'h08;
	localparam logic [7:0] OFF_PORT_STATE  = 8'h0c;
	localparam logic [7:0] OFF_RX_DATA     = 8'h10;
	localparam logic [7:0] OFF_TX_DATA     = 8'h14;

	// Bit positions of the control register fields.
	localparam int BIT_SIGN_EXT = 15;
	localparam int BIT_FRM_EN   = 12;
	localparam int BIT_ROV_EN   = 11;
	localparam int BIT_TUR_EN   = 10;
	localparam int BIT_ROV_TOL  = 9;
	localparam int BIT_TUR_TOL  = 8;
	localparam int BIT_AUD_EN   = 7;
	localparam int BIT_MONO     = 3;
	localparam int BIT_FMT_LSB  = 0;

	// Event bit positions in the status and mask registers.
	localparam int EVT_FRAME = 0;
	localparam int EVT_ROV   = 1;
	localparam int EVT_TUR   = 2;
	localparam int EVT_W     = 3;

	// Bit positions of the port state register.
	localparam int ST_RUN     = 0;
	localparam int ST_HALT    = 1;
	localparam int ST_RX_FULL = 2;
	localparam int ST_TX_FULL = 3;

	// Data bit delays after a slot boundary for the fixed framings.
	localparam int DELAY_I2S  = 1;
	localparam int DELAY_LEFT = 0;
	localparam int DELAY_PCM  = 1;

	// Framing format codes.
	typedef enum logic [1:0] {
		FMT_I2S   = 2'b00,
		FMT_LEFT  = 2'b01,
		FMT_RIGHT = 2'b10,
		FMT_PCM   = 2'b11
	} frame_fmt_t;

	// Run state of the port.
	typedef enum logic [1:0] {
		PORT_IDLE,
		PORT_RUN,
		PORT_HALT
	} port_state_t;

	// Implemented fields of the control register.
	typedef struct packed {
		logic       rx_sign_extend;
		logic       frame_err_event_en;
		logic       rx_overflow_event_en;
		logic       tx_underrun_event_en;
		logic       rx_overflow_tolerate;
		logic       tx_underrun_tolerate;
		logic       codec_protocol_en;
		logic       mono_format;
		frame_fmt_t codec_frame_format;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '0;

	// Link pins after synchronisation, clock first.
	typedef struct packed {
		logic sclk;
		logic fs;
		logic sdi;
	} link_in_t;

	// Places the control fields at their register positions; the rest reads zero.
	function automatic logic [31:0] ctrl_to_word(input ctrl_t c);
		logic [31:0] w;
		w = '0;
		w[BIT_SIGN_EXT] = c.rx_sign_extend;
		w[BIT_FRM_EN]   = c.frame_err_event_en;
		w[BIT_ROV_EN]   = c.rx_overflow_event_en;
		w[BIT_TUR_EN]   = c.tx_underrun_event_en;
		w[BIT_ROV_TOL]  = c.rx_overflow_tolerate;
		w[BIT_TUR_TOL]  = c.tx_underrun_tolerate;
		w[BIT_AUD_EN]   = c.codec_protocol_en;
		w[BIT_MONO]     = c.mono_format;
		w[BIT_FMT_LSB+1:BIT_FMT_LSB] = c.codec_frame_format;
		return w;
	endfunction

endpackage

/* File: verilog/link_sync.sv */
// Two-flop synchroniser for a group of link pins.
// Assumes the inputs are asynchronous to clk_i; only the second flop is read outside.
`timescale 1ns/1ns
module link_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;

	// Both stages reset to zero; the output then follows the pins two edges late.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= '0;
			sync_o   <= '0;
		end
		else
		begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule // link_sync

/* File: verilog/spi_audio_error_control.sv */
// Error handling and audio framing control for a serial audio port, with its link engine.
// Assumes port_en_i comes from port logic on clk_i and the link pins are asynchronous.
//
// What this block does
// - A word read from the receive holding register is sign-extended when rx_sign_extend is 1.
// - A frame error raises an error event only when frame_err_event_en is 1.
// - A receive overflow raises an error event only when rx_overflow_event_en is 1.
// - A transmit underrun raises an error event only when tx_underrun_event_en is 1.
// - With rx_overflow_tolerate set an overflow keeps the port running and drops the new word.
// - With rx_overflow_tolerate clear an overflow halts the port.
// - With tx_underrun_tolerate set an underrun sends zero words until data is written again.
// - With tx_underrun_tolerate clear an underrun halts the port.
// - codec_protocol_en switches the link into audio protocol framing.
// - With mono_format set each word goes out on both the left and the right slot.
// - codec_frame_format picks I2S, left justified, right justified or PCM framing.
// - codec_protocol_en, mono_format and codec_frame_format take writes only while port_en_i is 0.
// - mono_format and codec_frame_format act only while codec_protocol_en is 1.
// - Bits 31 to 16 and all unused control bits read as zero.
`timescale 1ns/1ns
module spi_audio_error_control #(
	parameter int DATA_W    = 16,
	parameter int SLOT_BITS = 32
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        port_en_i,
	input  wire logic        link_sclk_i,
	input  wire logic        link_fs_i,
	input  wire logic        link_sdi_i,
	output logic             link_sdo_o,
	output logic             err_event_o,
	output logic             port_stopped_o,
	output logic             irq_o
);

	localparam int POS_W = $clog2(SLOT_BITS);
	localparam int PW1   = POS_W + 1;
	localparam logic [POS_W-1:0] SLOT_LAST = POS_W'(SLOT_BITS - 1);
	localparam int EVT_W_L = spi_audio_pkg::EVT_W;

	spi_audio_pkg::ctrl_t       ctrl_reg;
	spi_audio_pkg::port_state_t state_reg;
	spi_audio_pkg::link_in_t    lnk;
	logic [2:0]                 sync_lvl;
	logic [EVT_W_L-1:0]         status_reg;
	logic [EVT_W_L-1:0]         mask_reg;
	logic [EVT_W_L-1:0]         stat_taken_reg;
	logic [EVT_W_L-1:0]         evt;
	logic                       ack_reg;
	logic [31:0]                rdata_reg;
	logic [31:0]                read_mux;
	logic                       rx_taken_reg;
	logic                       rx_full_reg;
	logic [DATA_W-1:0]          rx_word_reg;
	logic [DATA_W-1:0]          rx_shift_reg;
	logic                       tx_full_reg;
	logic [DATA_W-1:0]          tx_buf_reg;
	logic [DATA_W-1:0]          tx_shift_reg;
	logic [DATA_W-1:0]          tx_mono_reg;
	logic                       sclk_prev_reg;
	logic                       fs_prev_reg;
	logic [POS_W-1:0]           pos_reg;
	logic                       chan_reg;
	logic                       synced_reg;
	logic                       sdo_next_reg;
	logic                       req;
	logic                       wr_go;
	logic                       rd_go;
	logic                       running;
	logic                       sclk_rise;
	logic                       sclk_fall;
	logic                       fs_event;
	logic                       slot_start;
	logic                       frame_err;
	logic                       word_done;
	logic                       rx_bit_en;
	logic                       receive_overflow;
	logic                       transmit_underrun;
	logic                       critical;
	logic                       load;
	logic                       up_chan;
	logic                       fetch;
	logic                       chan_now;
	logic                       eff_mono;
	logic [POS_W-1:0]           pos_now;
	logic [POS_W-1:0]           nxt;
	logic [POS_W-1:0]           delay;
	logic [DATA_W-1:0]          fetched;
	logic [DATA_W-1:0]          word_src;
	spi_audio_pkg::frame_fmt_t  eff_fmt;

	// Bit delay from a slot boundary to the first data bit for a framing.
	function automatic logic [POS_W-1:0] delay_of(input spi_audio_pkg::frame_fmt_t f);
		case (f)
			spi_audio_pkg::FMT_I2S:   delay_of = POS_W'(spi_audio_pkg::DELAY_I2S);
			spi_audio_pkg::FMT_LEFT:  delay_of = POS_W'(spi_audio_pkg::DELAY_LEFT);
			spi_audio_pkg::FMT_RIGHT: delay_of = POS_W'(SLOT_BITS - DATA_W);
			default:                  delay_of = POS_W'(spi_audio_pkg::DELAY_PCM);
		endcase
	endfunction

	// True when slot position p carries a data bit.
	function automatic logic in_word(input logic [POS_W-1:0] p, input logic [POS_W-1:0] d);
		in_word = (p >= d) && ({1'b0, p} < ({1'b0, d} + PW1'(DATA_W)));
	endfunction

	// Pins pass two flops before the edge detection reads them.
	link_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i({link_sclk_i, link_fs_i, link_sdi_i}),
		.sync_o (sync_lvl)
	);

	assign lnk = spi_audio_pkg::link_in_t'(sync_lvl);

	// Wishbone handshake: one wait state, effects at the edge that sees ack.
	assign req      = wb_cyc_i & wb_stb_i;
	assign wr_go    = req & ack_reg & wb_we_i;
	assign rd_go    = req & ack_reg & ~wb_we_i;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// Framing in effect: plain left-justified stereo while audio is off.
	assign eff_fmt  = ctrl_reg.codec_protocol_en ? ctrl_reg.codec_frame_format
		: spi_audio_pkg::FMT_LEFT;
	assign eff_mono = ctrl_reg.codec_protocol_en & ctrl_reg.mono_format;
	assign delay    = delay_of(eff_fmt);

	// Link edge and slot bookkeeping, evaluated at each sampled clock rise.
	assign running   = (state_reg == spi_audio_pkg::PORT_RUN);
	assign sclk_rise = lnk.sclk & ~sclk_prev_reg;
	assign sclk_fall = ~lnk.sclk & sclk_prev_reg;
	assign fs_event  = running & sclk_rise & ((eff_fmt == spi_audio_pkg::FMT_PCM)
		? (lnk.fs & ~fs_prev_reg) : (lnk.fs ^ fs_prev_reg));
	assign slot_start = fs_event | (running & sclk_rise & synced_reg & (pos_reg == SLOT_LAST));
	assign frame_err  = fs_event & synced_reg & (pos_reg != SLOT_LAST);
	assign pos_now    = slot_start ? '0 : ((pos_reg == SLOT_LAST) ? pos_reg : pos_reg + 1'b1);
	assign nxt        = (pos_now == SLOT_LAST) ? '0 : pos_now + 1'b1;
	assign rx_bit_en  = running & sclk_rise & (synced_reg | fs_event) & in_word(pos_now, delay);
	assign word_done  = rx_bit_en & ({1'b0, pos_now} == ({1'b0, delay} + PW1'(DATA_W - 1)));
	assign receive_overflow        = word_done & rx_full_reg;
	assign chan_now   = fs_event ? ((eff_fmt == spi_audio_pkg::FMT_PCM) ? 1'b0 : lnk.fs)
		: (slot_start ? ~chan_reg : chan_reg);
	assign load       = running & sclk_rise & (synced_reg | fs_event)
		& ((nxt == '0) | (fs_event & (pos_reg != SLOT_LAST)));
	assign up_chan    = (nxt == '0) ? ~chan_now : chan_now;
	assign fetch      = load & (~eff_mono | ~up_chan);
	assign transmit_underrun        = fetch & ~tx_full_reg;
	assign critical   = (receive_overflow & ~ctrl_reg.rx_overflow_tolerate)
		| (transmit_underrun & ~ctrl_reg.tx_underrun_tolerate);
	assign fetched    = tx_full_reg ? tx_buf_reg : '0;
	assign word_src   = load ? (fetch ? fetched : tx_mono_reg) : tx_shift_reg;

	// Enabled error events; disabled ones leave no trace.
	assign evt[spi_audio_pkg::EVT_FRAME] = frame_err & ctrl_reg.frame_err_event_en;
	assign evt[spi_audio_pkg::EVT_ROV]   = receive_overflow & ctrl_reg.rx_overflow_event_en;
	assign evt[spi_audio_pkg::EVT_TUR]   = transmit_underrun & ctrl_reg.tx_underrun_event_en;
	assign err_event_o    = |evt;
	assign irq_o          = |(status_reg & mask_reg);
	assign port_stopped_o = (state_reg == spi_audio_pkg::PORT_HALT);

	// Read multiplexer; unmapped offsets read zero.
	always_comb
	begin
		read_mux = '0;
		if (wb_adr_i == spi_audio_pkg::OFF_CONTROL_TWO)
			read_mux = spi_audio_pkg::ctrl_to_word(ctrl_reg);
		else if (wb_adr_i == spi_audio_pkg::OFF_INT_STATUS)
			read_mux[EVT_W_L-1:0] = status_reg;
		else if (wb_adr_i == spi_audio_pkg::OFF_INT_MASK)
			read_mux[EVT_W_L-1:0] = mask_reg;
		else if (wb_adr_i == spi_audio_pkg::OFF_PORT_STATE)
		begin
			read_mux[spi_audio_pkg::ST_RUN]     = running;
			read_mux[spi_audio_pkg::ST_HALT]    = port_stopped_o;
			read_mux[spi_audio_pkg::ST_RX_FULL] = rx_full_reg;
			read_mux[spi_audio_pkg::ST_TX_FULL] = tx_full_reg;
		end
		else if (wb_adr_i == spi_audio_pkg::OFF_RX_DATA)
			read_mux = {{(32 - DATA_W){ctrl_reg.rx_sign_extend & rx_word_reg[DATA_W-1]}},
				rx_word_reg};
	end

	// Ack and read data; remember what a read handed out so only that is cleared.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg        <= 1'b0;
			rdata_reg      <= '0;
			stat_taken_reg <= '0;
			rx_taken_reg   <= 1'b0;
		end
		else
		begin
			ack_reg <= req & ~ack_reg;
			if (req & ~ack_reg & ~wb_we_i)
			begin
				rdata_reg      <= read_mux;
				stat_taken_reg <= (wb_adr_i == spi_audio_pkg::OFF_INT_STATUS) ? status_reg : '0;
				rx_taken_reg   <= (wb_adr_i == spi_audio_pkg::OFF_RX_DATA) & rx_full_reg;
			end
		end
	end

	// Control register; protocol fields are frozen while the port is enabled.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_reg <= spi_audio_pkg::CTRL_RESET;
		else if (wr_go & (wb_adr_i == spi_audio_pkg::OFF_CONTROL_TWO))
		begin
			if (wb_sel_i[1])
			begin
				ctrl_reg.rx_sign_extend       <= wb_dat_i[spi_audio_pkg::BIT_SIGN_EXT];
				ctrl_reg.frame_err_event_en   <= wb_dat_i[spi_audio_pkg::BIT_FRM_EN];
				ctrl_reg.rx_overflow_event_en <= wb_dat_i[spi_audio_pkg::BIT_ROV_EN];
				ctrl_reg.tx_underrun_event_en <= wb_dat_i[spi_audio_pkg::BIT_TUR_EN];
				ctrl_reg.rx_overflow_tolerate <= wb_dat_i[spi_audio_pkg::BIT_ROV_TOL];
				ctrl_reg.tx_underrun_tolerate <= wb_dat_i[spi_audio_pkg::BIT_TUR_TOL];
			end
			if (wb_sel_i[0] & ~port_en_i)
			begin
				ctrl_reg.codec_protocol_en  <= wb_dat_i[spi_audio_pkg::BIT_AUD_EN];
				ctrl_reg.mono_format        <= wb_dat_i[spi_audio_pkg::BIT_MONO];
				ctrl_reg.codec_frame_format <= spi_audio_pkg::frame_fmt_t'(
					wb_dat_i[spi_audio_pkg::BIT_FMT_LSB+1:spi_audio_pkg::BIT_FMT_LSB]);
			end
		end
	end

	// Sticky status, cleared by reading it; a new event wins over the clear.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_reg <= '0;
		else
			status_reg <= (status_reg & ~(rd_go ? stat_taken_reg : '0)) | evt;
	end

	// Interrupt mask register.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mask_reg <= '0;
		else if (wr_go & (wb_adr_i == spi_audio_pkg::OFF_INT_MASK) & wb_sel_i[0])
			mask_reg <= wb_dat_i[EVT_W_L-1:0];
	end

	// Port run state; a critical error halts until the port is disabled.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_reg <= spi_audio_pkg::PORT_IDLE;
		else
		begin
			case (state_reg)
				spi_audio_pkg::PORT_IDLE:
					if (port_en_i)
						state_reg <= spi_audio_pkg::PORT_RUN;
				spi_audio_pkg::PORT_RUN:
					if (~port_en_i)
						state_reg <= spi_audio_pkg::PORT_IDLE;
					else if (critical)
						state_reg <= spi_audio_pkg::PORT_HALT;
				default:
					if (~port_en_i)
						state_reg <= spi_audio_pkg::PORT_IDLE;
			endcase
		end
	end

	// Receive holding word; an overflow keeps the held word untouched.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_shift_reg <= '0;
			rx_word_reg  <= '0;
			rx_full_reg  <= 1'b0;
		end
		else
		begin
			if (rx_bit_en)
				rx_shift_reg <= {rx_shift_reg[DATA_W-2:0], lnk.sdi};
			if (word_done & ~rx_full_reg)
			begin
				rx_word_reg <= {rx_shift_reg[DATA_W-2:0], lnk.sdi};
				rx_full_reg <= 1'b1;
			end
			else if (rd_go & rx_taken_reg)
				rx_full_reg <= 1'b0;
		end
	end

	// Transmit buffer; a write in the fetch cycle still lands.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_buf_reg  <= '0;
			tx_full_reg <= 1'b0;
		end
		else if (wr_go & (wb_adr_i == spi_audio_pkg::OFF_TX_DATA))
		begin
			for (int b = 0; b < DATA_W / 8; b++)
				if (wb_sel_i[b])
					tx_buf_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
			tx_full_reg <= 1'b1;
		end
		else if (fetch)
			tx_full_reg <= 1'b0;
	end

	// Slot position, channel and alignment tracking on the link.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sclk_prev_reg <= 1'b0;
			fs_prev_reg   <= 1'b0;
			pos_reg       <= '0;
			chan_reg      <= 1'b0;
			synced_reg    <= 1'b0;
		end
		else
		begin
			sclk_prev_reg <= lnk.sclk;
			if (~running)
			begin
				synced_reg <= 1'b0;
				pos_reg    <= '0;
				fs_prev_reg <= lnk.fs;
			end
			else if (sclk_rise)
			begin
				fs_prev_reg <= lnk.fs;
				pos_reg     <= pos_now;
				chan_reg    <= chan_now;
				if (fs_event)
					synced_reg <= 1'b1;
			end
		end
	end

	// Transmit shifter: next bit prepared at a rise, driven at the following fall.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_shift_reg <= '0;
			tx_mono_reg  <= '0;
			sdo_next_reg <= 1'b0;
			link_sdo_o   <= 1'b0;
		end
		else if (~running)
		begin
			sdo_next_reg <= 1'b0;
			link_sdo_o   <= 1'b0;
		end
		else
		begin
			if (sclk_rise)
			begin
				if (fetch)
					tx_mono_reg <= fetched;
				if (in_word(nxt, delay))
				begin
					sdo_next_reg <= word_src[DATA_W-1];
					tx_shift_reg <= {word_src[DATA_W-2:0], 1'b0};
				end
				else
				begin
					sdo_next_reg <= 1'b0;
					tx_shift_reg <= word_src;
				end
			end
			if (sclk_fall)
				link_sdo_o <= sdo_next_reg;
		end
	end

	property p_sign_ext;
		@(posedge clk_i) disable iff (rst_i)
		(req & ~ack_reg & ~wb_we_i & (wb_adr_i == spi_audio_pkg::OFF_RX_DATA)
			& ctrl_reg.rx_sign_extend & rx_word_reg[DATA_W-1]) |=> (wb_dat_o[31] & wb_ack_o);
	endproperty
	a_sign_ext: assert property (p_sign_ext) else $error("Read word not sign-extended.");

	property p_frame_evt;
		@(posedge clk_i) disable iff (rst_i)
		frame_err |=> (status_reg[spi_audio_pkg::EVT_FRAME] == $past(ctrl_reg.frame_err_event_en))
			|| $past(status_reg[spi_audio_pkg::EVT_FRAME]);
	endproperty
	a_frame_evt: assert property (p_frame_evt) else $error("Frame error event gating wrong.");

	property p_rov_evt;
		@(posedge clk_i) disable iff (rst_i)
		(receive_overflow & ctrl_reg.rx_overflow_event_en) |=> status_reg[spi_audio_pkg::EVT_ROV];
	endproperty
	a_rov_evt: assert property (p_rov_evt) else $error("Overflow event not recorded.");

	property p_tur_evt;
		@(posedge clk_i) disable iff (rst_i)
		(transmit_underrun & ~ctrl_reg.tx_underrun_event_en) |-> ~err_event_o | frame_err | receive_overflow;
	endproperty
	a_tur_evt: assert property (p_tur_evt) else $error("Disabled underrun raised event.");

	property p_rov_tol;
		@(posedge clk_i) disable iff (rst_i)
		(receive_overflow & ctrl_reg.rx_overflow_tolerate & ~transmit_underrun & port_en_i)
			|=> (state_reg == spi_audio_pkg::PORT_RUN) & $stable(rx_word_reg);
	endproperty
	a_rov_tol: assert property (p_rov_tol) else $error("Tolerated overflow disturbed port.");

	property p_rov_crit;
		@(posedge clk_i) disable iff (rst_i)
		(receive_overflow & ~ctrl_reg.rx_overflow_tolerate & port_en_i) |=> port_stopped_o;
	endproperty
	a_rov_crit: assert property (p_rov_crit) else $error("Critical overflow did not halt.");

	property p_tur_zero;
		@(posedge clk_i) disable iff (rst_i)
		(transmit_underrun & ctrl_reg.tx_underrun_tolerate & port_en_i & ~receive_overflow) |=> (tx_shift_reg == '0)
			& ~sdo_next_reg & (state_reg == spi_audio_pkg::PORT_RUN);
	endproperty
	a_tur_zero: assert property (p_tur_zero) else $error("Underrun did not send zeros.");

	property p_tur_crit;
		@(posedge clk_i) disable iff (rst_i)
		(transmit_underrun & ~ctrl_reg.tx_underrun_tolerate & port_en_i) |=> port_stopped_o ##1 port_stopped_o
			|| ~port_en_i;
	endproperty
	a_tur_crit: assert property (p_tur_crit) else $error("Critical underrun did not halt.");

	property p_lock;
		@(posedge clk_i) disable iff (rst_i)
		port_en_i |=> $stable(ctrl_reg.codec_protocol_en) & $stable(ctrl_reg.mono_format)
			& $stable(ctrl_reg.codec_frame_format);
	endproperty
	a_lock: assert property (p_lock) else $error("Protocol field changed while enabled.");

	property p_aud_off;
		@(posedge clk_i) disable iff (rst_i)
		~ctrl_reg.codec_protocol_en |-> ~eff_mono & (eff_fmt == spi_audio_pkg::FMT_LEFT);
	endproperty
	a_aud_off: assert property (p_aud_off) else $error("Audio fields acted while off.");

endmodule // spi_audio_error_control

/* File: test/codec_peer.sv */
// Behavioural audio codec that makes the link clock and frame sync and sends one word per slot.
// Assumes a 32-bit slot (24 while short_i is high to force frame errors), a 16-bit word
// sent MSB first, and a bit clock of 160 ns.
`timescale 1ns/1ns
module codec_peer #(
	parameter logic [15:0] WORD = 16'h8001
) (
	input  wire logic run_i,
	input  wire logic short_i,
	input  wire logic sdo_i,
	output logic      sclk_o,
	output logic      fs_o,
	output logic      sdi_o,
	output logic      sdo_seen_o
);
	int unsigned bit_idx;
	int unsigned slot_n;

	// Slots run while run_i is high; the clock stands low between them.
	// Past the word, sdi toggles so that a stale bit is never mistaken for data.
	// Ones on sdo count only after the first slot, where an underrun must send zeros.
	initial
	begin
		sclk_o = 1'b0;
		fs_o = 1'b0;
		sdi_o = 1'b0;
		sdo_seen_o = 1'b0;
		slot_n = 0;
		forever
		begin
			wait (run_i);
			#3;
			fs_o = ~fs_o;
			for (bit_idx = 0; bit_idx < (short_i ? 24 : 32); bit_idx++)
			begin
				sdi_o = (bit_idx < 16) ? WORD[15 - bit_idx] : ~sdi_o;
				#80 sclk_o = 1'b1;
				sdo_seen_o = sdo_seen_o | (sdo_i & (slot_n != 0));
				#80 sclk_o = 1'b0;
			end
			slot_n++;
		end
	end
endmodule // codec_peer

/* File: test/testbench.sv */
// Self-checking bench for the serial audio error control block.
// Assumes the package is compiled first and the codec model drives the link pins.
`timescale 1ns/1ns
module testbench;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [7:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        port_en;
	logic        run;
	logic        short_slot;
	logic        err_evt;
	logic        sclk;
	logic        fs;
	logic        sdi;
	logic        sdo;
	logic        sdo_seen;
	logic        stopped;
	logic        irq;
	logic [31:0] rdat;
	int          miscompares = 0;
	int          checks_done = 0;
	int          err_evts = 0;
	int          evts_before;

	spi_audio_error_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .port_en_i(port_en),
		.link_sclk_i(sclk), .link_fs_i(fs), .link_sdi_i(sdi), .link_sdo_o(sdo),
		.err_event_o(err_evt), .port_stopped_o(stopped), .irq_o(irq));
	codec_peer peer (.run_i(run), .short_i(short_slot), .sdo_i(sdo), .sclk_o(sclk),
		.fs_o(fs), .sdi_o(sdi), .sdo_seen_o(sdo_seen));

	// Counts error event pulses mid-cycle, where the output has settled.
	always @(negedge clk_i)
	begin
		if (err_evt === 1'b1)
			err_evts++;
	end

	// Free-running system clock.
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Compares one value and counts it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One classic cycle; the request holds until ack is sampled high.
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		@(posedge clk_i);
		while (wb_ack !== 1'b1)
			@(posedge clk_i);
		rdat = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// Reads a register and compares it.
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		xfer(1'b0, adr, 32'h0);
		check(rdat, exp);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Cuts a hang short well past the expected run length.
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		complete_run();
	end

	// Main sequence: register access, tolerated errors, a critical underrun, then frame errors in mono.
	initial
	begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 32'h0;
		port_en = 1'b0;
		run = 1'b0;
		short_slot = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(spi_audio_pkg::OFF_CONTROL_TWO, 32'h0);
		rd_chk(8'h20, 32'h0);
		xfer(1'b1, spi_audio_pkg::OFF_CONTROL_TWO, 32'hffffffff);
		rd_chk(spi_audio_pkg::OFF_CONTROL_TWO, 32'h00009f8b);
		port_en <= 1'b1;
		xfer(1'b1, spi_audio_pkg::OFF_CONTROL_TWO, 32'h0);
		rd_chk(spi_audio_pkg::OFF_CONTROL_TWO, 32'h0000008b);
		port_en <= 1'b0;
		xfer(1'b1, spi_audio_pkg::OFF_CONTROL_TWO, 32'h00009f00);
		xfer(1'b1, spi_audio_pkg::OFF_INT_MASK, 32'h7);
		xfer(1'b1, spi_audio_pkg::OFF_TX_DATA, 32'h0000ffff);
		rd_chk(spi_audio_pkg::OFF_PORT_STATE, 32'h8);
		port_en <= 1'b1;
		run <= 1'b1;
		repeat (1200) @(posedge clk_i);
		run <= 1'b0;
		repeat (700) @(posedge clk_i);
		check({31'h0, irq}, 32'h1);
		check({31'h0, stopped}, 32'h0);
		check({31'h0, sdo_seen}, 32'h0);
		rd_chk(spi_audio_pkg::OFF_RX_DATA, 32'hffff8001);
		rd_chk(spi_audio_pkg::OFF_INT_STATUS, 32'h6);
		check({31'h0, irq}, 32'h0);
		check({31'h0, (err_evts != 0)}, 32'h1);
		evts_before = err_evts;
		port_en <= 1'b0;
		xfer(1'b1, spi_audio_pkg::OFF_CONTROL_TWO, 32'h00000800);
		port_en <= 1'b1;
		run <= 1'b1;
		repeat (600) @(posedge clk_i);
		run <= 1'b0;
		repeat (700) @(posedge clk_i);
		check({31'h0, stopped}, 32'h1);
		rd_chk(spi_audio_pkg::OFF_INT_STATUS, 32'h0);
		check(err_evts, evts_before);
		port_en <= 1'b0;
		repeat (3) @(posedge clk_i);
		check({31'h0, stopped}, 32'h0);
		xfer(1'b1, spi_audio_pkg::OFF_CONTROL_TWO, 32'h00001389);
		rd_chk(spi_audio_pkg::OFF_CONTROL_TWO, 32'h00001389);
		port_en <= 1'b1;
		short_slot <= 1'b1;
		run <= 1'b1;
		repeat (1200) @(posedge clk_i);
		run <= 1'b0;
		repeat (700) @(posedge clk_i);
		check({31'h0, stopped}, 32'h0);
		rd_chk(spi_audio_pkg::OFF_INT_STATUS, 32'h1);
		complete_run();
	end
endmodule // testbench
